// *** core/pka_pkg.sv ***
// Constants and types of the public-key arithmetic unit routines block.
// Assumes a single clock domain; no bus, all control bits are plain ports.
package pka_pkg;
    // ==========================================================
    // Data path sizes
    localparam int DIGIT_W = 16;
    localparam int IDX_W = 4;
    localparam int SEL_W = 2;
    localparam int ADDR_W = SEL_W + IDX_W;
    localparam int MEM_DEPTH = 1 << ADDR_W;
    localparam int RAM_COUNT = 4;
    localparam int R2_SHIFT_W = 5;
    localparam int DBL_W = IDX_W + R2_SHIFT_W;
    localparam logic [ADDR_W-1:0] MEM_LAST = 6'h3F;
    localparam logic [DIGIT_W-1:0] DIGIT_ZERO = 16'h0000;
    localparam logic [DIGIT_W-1:0] DIGIT_ONE = 16'h0001;
    localparam logic [IDX_W-1:0] IDX_ZERO = 4'h0;
    // ==========================================================
    // RAM numbers and fixed sub-registers
    localparam logic [SEL_W-1:0] RAM_A = 2'h0;
    localparam logic [SEL_W-1:0] RAM_B = 2'h1;
    localparam logic [SEL_W-1:0] RAM_N = 2'h2;
    localparam logic [SEL_W-1:0] RAM_T = 2'h3;
    localparam logic [SEL_W-1:0] B1_SEL = 2'h1;
    localparam logic [SEL_W-1:0] T_SEL = 2'h0;
    // ==========================================================
    // Routine entry addresses
    localparam int ENTRY_W = 4;
    localparam logic [ENTRY_W-1:0] ENTRY_SUB = 4'h9;
    localparam logic [ENTRY_W-1:0] ENTRY_R2 = 4'hC;
    localparam logic [ENTRY_W-1:0] ENTRY_CLEAR = 4'hD;
    // ==========================================================
    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_CLEAR = 3'h1,
        ST_SUB1 = 3'h2,
        ST_SUB2 = 3'h3,
        ST_R2INIT = 3'h4,
        ST_R2DBL = 3'h5,
        ST_R2COPY = 3'h6
    } pka_state_type;
endpackage

// *** core/pka_routines.sv ***
// Modular subtract, clear memory and squared-radix routines with A, B, N, t RAMs.
// Assumes host control ports on clk; host holds controls steady while busy.
//
// Contract
// [R1] Subtraction gives A-B when A is not below B, otherwise A-B plus N.
// [R2] The subtraction result is written over the selected B sub-register.
// [R3] The host gives operands below N and a digit-count setting of three or more.
// [R4] The host sets the A and B operand pointers before starting subtraction.
// [R5] Subtraction has no mode input and treats residue and plain operands alike.
// [R6] Clearing writes zero to every location of the A, B, N and t RAMs.
// [R7] Clearing touches no control state, which changes only by reset or host.
// [R8] Any hardware or software reset starts the clearing routine by itself.
// [R9] Done rises only after the reset-started clearing has finished.
// [R10] The squared-radix routine computes 2 to the 32 times digit count, mod N.
// [R11] The host runs the squared-radix routine only with binary field select low.
// [R12] The host gives at least four digits and a non-zero top modulus digit.
// [R13] The host sets digit count minus one and loads the modulus into N first.
// [R14] The squared-radix result lands in B1 and N is left as it was.
// [R15] The host should store the squared-radix value rather than recompute it.
// [R16] A start with a known entry address runs that routine and sets done at its end, except squared-radix with binary field select high.
`timescale 1ns/10ps
`default_nettype none
module pka_routines (
    input wire logic clk,
    input wire logic reset,
    input wire logic soft_reset,
    input wire logic start,
    input wire logic [pka_pkg::ENTRY_W-1:0] entry_addr,
    input wire logic [pka_pkg::SEL_W-1:0] a_sel,
    input wire logic [pka_pkg::SEL_W-1:0] b_sel,
    input wire logic [pka_pkg::SEL_W-1:0] n_sel,
    input wire logic [pka_pkg::IDX_W-1:0] mod_size,
    input wire logic binary_field_select,
    input wire logic host_we,
    input wire logic [pka_pkg::SEL_W-1:0] host_ram,
    input wire logic [pka_pkg::ADDR_W-1:0] host_addr,
    input wire logic [pka_pkg::DIGIT_W-1:0] host_wdata,
    output logic [pka_pkg::DIGIT_W-1:0] host_rdata,
    output logic busy,
    output logic done
);
    import pka_pkg::*;

    // ==========================================================
    // Storage
    logic [DIGIT_W-1:0] ram [RAM_COUNT][MEM_DEPTH];
    logic [RAM_COUNT-1:0] ram_we;
    logic [ADDR_W-1:0] ram_waddr [RAM_COUNT];
    logic [DIGIT_W-1:0] ram_wdata [RAM_COUNT];

    pka_state_type state, next_state;
    logic [ADDR_W-1:0] idx, next_idx;
    logic cy, next_cy;
    logic flag, next_flag;
    logic shift, next_shift;
    logic [DBL_W-1:0] dbl, next_dbl;
    logic next_done;
    logic next_busy;

    logic [IDX_W-1:0] dig;
    logic last_digit;
    logic [DBL_W-1:0] last_dbl;
    logic [DIGIT_W-1:0] a_rd, b_rd, n_rd, t_rd, b1_rd;
    logic [DIGIT_W:0] sub_diff, add_sum, dbl_diff;
    logic keep;

    assign dig = idx[IDX_W-1:0];
    assign last_digit = (dig == mod_size);
    // Doublings needed: (mod_size+1)*32, counted from zero
    assign last_dbl = {mod_size, {R2_SHIFT_W{1'b1}}}; // R10
    assign a_rd = ram[RAM_A][{a_sel, dig}];
    assign b_rd = ram[RAM_B][{b_sel, dig}];
    assign n_rd = ram[RAM_N][{n_sel, dig}];
    assign t_rd = ram[RAM_T][{T_SEL, dig}];
    assign b1_rd = ram[RAM_B][{B1_SEL, dig}];
    // No mode input: residue form changes nothing here
    assign sub_diff = {1'b0, a_rd} - {1'b0, b_rd} - {{DIGIT_W{1'b0}}, cy}; // R5
    assign add_sum = {1'b0, t_rd} + {1'b0, flag ? n_rd : DIGIT_ZERO} + {{DIGIT_W{1'b0}}, cy}; // R1
    assign dbl_diff = {1'b0, b1_rd[DIGIT_W-2:0], shift} - {1'b0, n_rd} - {{DIGIT_W{1'b0}}, cy}; // R10
    // Keep 2x-N if 2x overflowed or the subtraction did not borrow
    assign keep = b1_rd[DIGIT_W-1] | ~dbl_diff[DIGIT_W];

    // ==========================================================
    // Sequencer next state
    always_comb begin
        next_state = state;
        next_idx = idx;
        next_cy = cy;
        next_flag = flag;
        next_shift = shift;
        next_dbl = dbl;
        next_done = done;
        ram_we = '0;
        for (int r = 0; r < RAM_COUNT; r++) begin
            ram_waddr[r] = '0;
            ram_wdata[r] = DIGIT_ZERO;
        end
        case (state)
            ST_IDLE: begin
                if (host_we) begin
                    ram_we[host_ram] = 1'b1;
                    ram_waddr[host_ram] = host_addr;
                    ram_wdata[host_ram] = host_wdata;
                end
                next_idx = '0;
                next_cy = 1'b0;
                if (start) begin
                    case (entry_addr)
                        ENTRY_SUB: begin
                            next_state = ST_SUB1; // R16
                            next_done = 1'b0;
                        end
                        ENTRY_R2: begin
                            // Binary field unsupported: start is ignored
                            if (!binary_field_select) begin // R11
                                next_state = ST_R2INIT;
                                next_done = 1'b0;
                            end
                        end
                        ENTRY_CLEAR: begin
                            next_state = ST_CLEAR;
                            next_done = 1'b0;
                        end
                        default: next_state = ST_IDLE;
                    endcase
                end
            end
            ST_CLEAR: begin
                ram_we = '1; // R6
                for (int r = 0; r < RAM_COUNT; r++) begin
                    ram_waddr[r] = idx;
                end
                next_idx = idx + 1'b1;
                if (idx == MEM_LAST) begin
                    next_state = ST_IDLE;
                    next_done = 1'b1; // R9
                end
            end
            ST_SUB1: begin
                ram_we[RAM_T] = 1'b1;
                ram_waddr[RAM_T] = {T_SEL, dig};
                ram_wdata[RAM_T] = sub_diff[DIGIT_W-1:0];
                next_cy = sub_diff[DIGIT_W];
                next_idx = idx + 1'b1;
                if (last_digit) begin
                    next_flag = sub_diff[DIGIT_W]; // R1
                    next_cy = 1'b0;
                    next_idx = '0;
                    next_state = ST_SUB2;
                end
            end
            ST_SUB2: begin
                ram_we[RAM_B] = 1'b1;
                ram_waddr[RAM_B] = {b_sel, dig}; // R2
                ram_wdata[RAM_B] = add_sum[DIGIT_W-1:0];
                next_cy = add_sum[DIGIT_W];
                next_idx = idx + 1'b1;
                if (last_digit) begin
                    next_state = ST_IDLE;
                    next_done = 1'b1; // R16
                end
            end
            ST_R2INIT: begin
                ram_we[RAM_B] = 1'b1;
                ram_waddr[RAM_B] = {B1_SEL, dig};
                ram_wdata[RAM_B] = (dig == IDX_ZERO) ? DIGIT_ONE : DIGIT_ZERO;
                next_idx = idx + 1'b1;
                if (last_digit) begin
                    next_idx = '0;
                    next_cy = 1'b0;
                    next_shift = 1'b0;
                    next_dbl = '0;
                    next_state = ST_R2DBL;
                end
            end
            ST_R2DBL: begin
                ram_we[RAM_B] = 1'b1;
                ram_waddr[RAM_B] = {B1_SEL, dig};
                ram_wdata[RAM_B] = {b1_rd[DIGIT_W-2:0], shift}; // R10
                ram_we[RAM_T] = 1'b1;
                ram_waddr[RAM_T] = {T_SEL, dig};
                ram_wdata[RAM_T] = dbl_diff[DIGIT_W-1:0];
                next_cy = dbl_diff[DIGIT_W];
                next_shift = b1_rd[DIGIT_W-1];
                next_idx = idx + 1'b1;
                if (last_digit) begin
                    next_idx = '0;
                    next_cy = 1'b0;
                    next_shift = 1'b0;
                    if (keep) begin
                        next_state = ST_R2COPY;
                    end else if (dbl == last_dbl) begin
                        next_state = ST_IDLE; // R10
                        next_done = 1'b1;
                    end else begin
                        next_dbl = dbl + 1'b1;
                    end
                end
            end
            ST_R2COPY: begin
                ram_we[RAM_B] = 1'b1;
                ram_waddr[RAM_B] = {B1_SEL, dig}; // R14
                ram_wdata[RAM_B] = t_rd;
                next_idx = idx + 1'b1;
                if (last_digit) begin
                    next_idx = '0;
                    if (dbl == last_dbl) begin
                        next_state = ST_IDLE;
                        next_done = 1'b1;
                    end else begin
                        next_dbl = dbl + 1'b1;
                        next_state = ST_R2DBL;
                    end
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        // Soft reset restarts clearing like a hard one
        if (soft_reset) begin
            next_state = ST_CLEAR; // R8
            next_idx = '0;
            next_done = 1'b0;
        end
        next_busy = (next_state != ST_IDLE);
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clk) begin
        if (reset) begin
            state <= ST_CLEAR; // R8
            idx <= '0;
            cy <= 1'b0;
            flag <= 1'b0;
            shift <= 1'b0;
            dbl <= '0;
            done <= 1'b0;
            busy <= 1'b1;
        end else begin
            state <= next_state;
            idx <= next_idx;
            cy <= next_cy;
            flag <= next_flag;
            shift <= next_shift;
            dbl <= next_dbl;
            done <= next_done;
            busy <= next_busy;
        end
    end

    // RAMs carry no reset; clearing zeroes them, control ports stay the host's
    generate
        for (genvar r = 0; r < RAM_COUNT; r++) begin : g_ram
            always_ff @(posedge clk) begin
                if (ram_we[r]) begin
                    ram[r][ram_waddr[r]] <= ram_wdata[r]; // R7
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        host_rdata <= ram[host_ram][host_addr];
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence sub_first_pass;
        state == ST_SUB1 && last_digit;
    endsequence
    sequence sub_second_pass;
        state == ST_SUB2 && dig == IDX_ZERO;
    endsequence

    reset_starts_clear_a: assert property (@(posedge clk) disable iff (1'b0)
        reset |=> state == ST_CLEAR && idx == '0 && !done) else $error("reset did not start clearing"); // R8
    soft_starts_clear_a: assert property (soft_reset |=> state == ST_CLEAR && !done)
        else $error("soft reset did not start clearing"); // R8
    clear_zero_all_a: assert property (state == ST_CLEAR |-> ram_we == '1 && ram_wdata[RAM_N] == DIGIT_ZERO
        && ram_wdata[RAM_T] == DIGIT_ZERO && ram_waddr[RAM_A] == idx) else $error("clear wrote non-zero"); // R6
    clear_done_end_a: assert property (state == ST_CLEAR && idx != MEM_LAST |=> !done)
        else $error("done before clearing ended"); // R9
    sub_mod_fix_a: assert property (sub_first_pass ##1 sub_second_pass |->
        ram_wdata[RAM_B] == (flag ? DIGIT_W'(t_rd + n_rd) : t_rd)) else $error("wrong subtract fixup"); // R1
    sub_to_b_a: assert property (state == ST_SUB2 |-> ram_we == (1 << RAM_B) && ram_waddr[RAM_B] == {b_sel, dig})
        else $error("subtract result not in B"); // R2
    n_kept_a: assert property (state inside {ST_SUB1, ST_SUB2, ST_R2INIT, ST_R2DBL, ST_R2COPY} |-> !ram_we[RAM_N])
        else $error("routine wrote N"); // R14
    r2_count_a: assert property (state == ST_R2COPY && last_digit && dbl != last_dbl |=> state == ST_R2DBL
        && dbl == $past(dbl) + 1'b1) else $error("doubling count wrong"); // R10
    start_runs_a: assert property (state == ST_IDLE && start && !soft_reset && entry_addr == ENTRY_SUB
        |=> state == ST_SUB1 && busy && !done ##1 state == ST_SUB1) else $error("subtract did not start"); // R16
endmodule
`default_nettype wire

// *** verif/tb_pka_routines.sv ***
// =============================================================
// Self-checking bench for the subtract, clear and squared-radix routines.
// Assumes pka_pkg and pka_routines are compiled first; one 200 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module tb_pka_routines;
    import pka_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic soft_reset = 1'b0;
    logic start = 1'b0;
    logic [ENTRY_W-1:0] entry_addr = 4'h0;
    logic [SEL_W-1:0] a_sel = 2'h0;
    logic [SEL_W-1:0] b_sel = 2'h0;
    logic [SEL_W-1:0] n_sel = 2'h0;
    logic [IDX_W-1:0] mod_size = 4'h3;
    logic binary_field_select = 1'b0;
    logic host_we = 1'b0;
    logic [SEL_W-1:0] host_ram = 2'h0;
    logic [ADDR_W-1:0] host_addr = 6'h00;
    logic [DIGIT_W-1:0] host_wdata = 16'h0000;
    logic [DIGIT_W-1:0] host_rdata;
    logic busy;
    logic done;
    logic [63:0] rv;
    int miscompares = 0;
    int num_checks = 0;
    int cycles = 0;
    int n;

    pka_routines DUT (.clk(clk), .reset(reset), .soft_reset(soft_reset), .start(start),
        .entry_addr(entry_addr), .a_sel(a_sel), .b_sel(b_sel), .n_sel(n_sel), .mod_size(mod_size),
        .binary_field_select(binary_field_select), .host_we(host_we), .host_ram(host_ram),
        .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata), .busy(busy), .done(done));

    // =============================================================
    // Clock and hang guard
    initial begin
        forever #2.5 clk = ~clk;
    end
    // Longest run is the squared-radix routine, about a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            test_done();
        end
    end

    // =============================================================
    // Compare and bus helpers
    task automatic chk_vec(input string what, input logic [63:0] exp, input logic [63:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_bit(input string what, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask
    // Four 16-bit digits, least significant first
    task automatic wr(input logic [1:0] ram, input logic [1:0] sel, input logic [63:0] v);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            host_we <= 1'b1;
            host_ram <= ram;
            host_addr <= {sel, i[3:0]};
            host_wdata <= v[16*i+:16];
        end
        @(posedge clk);
        host_we <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] ram, input logic [1:0] sel, output logic [63:0] v);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            host_ram <= ram;
            host_addr <= {sel, i[3:0]};
            @(posedge clk);
            #1;
            v[16*i+:16] = host_rdata;
        end
    endtask
    task automatic run(input logic [3:0] e);
        @(posedge clk);
        start <= 1'b1;
        entry_addr <= e;
        @(posedge clk);
        start <= 1'b0;
        #1;
    endtask
    task automatic wait_done(output int cnt);
        cnt = 0;
        while (done !== 1'b1 && cnt < 3000) begin
            @(posedge clk);
            #1;
            cnt++;
        end
        chk_bit("done", 1'b1, done);
        chk_bit("busy", 1'b0, busy);
    endtask
    function automatic logic [63:0] r2_ref(input logic [63:0] m);
        logic [64:0] r;
        r = 65'h1;
        // R squared is 2 to the 128 for four digits
        repeat (128) begin
            r = r << 1;
            if (r >= {1'b0, m}) r = r - {1'b0, m};
        end
        return r[63:0];
    endfunction

    // =============================================================
    // Scenarios
    task automatic t_reset();
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        #1;
        chk_bit("busy after reset", 1'b1, busy);
        chk_bit("done after reset", 1'b0, done);
        wait_done(n);
        chk_vec("clear length", 64'h40, n);
        for (int r = 0; r < 4; r++) begin
            for (int s = 0; s < 4; s++) begin
                rd(r[1:0], s[1:0], rv);
                chk_vec("ram after reset", 64'h0, rv);
            end
        end
    endtask
    task automatic t_sub(input logic [63:0] a, input logic [63:0] b, input logic [63:0] m);
        a_sel <= 2'h1;
        b_sel <= 2'h2;
        n_sel <= 2'h3;
        wr(RAM_A, 2'h1, a);
        wr(RAM_B, 2'h2, b);
        wr(RAM_N, 2'h3, m);
        run(ENTRY_SUB);
        chk_bit("busy on start", 1'b1, busy);
        chk_bit("done on start", 1'b0, done);
        wait_done(n);
        chk_vec("subtract length", 64'h8, n);
        rd(RAM_B, 2'h2, rv);
        chk_vec("difference", (a >= b) ? a - b : a - b + m, rv);
    endtask
    task automatic t_refuse();
        binary_field_select <= 1'b1;
        run(ENTRY_R2);
        chk_bit("binary field start", 1'b0, busy);
        chk_bit("done kept", 1'b1, done);
        binary_field_select <= 1'b0;
        run(4'h0);
        chk_bit("unknown entry", 1'b0, busy);
    endtask
    task automatic t_r2(input logic [63:0] m);
        n_sel <= 2'h0;
        wr(RAM_N, 2'h0, m);
        run(ENTRY_R2);
        wait_done(n);
        rd(RAM_B, B1_SEL, rv);
        chk_vec("squared radix", r2_ref(m), rv);
        rd(RAM_N, 2'h0, rv);
        chk_vec("modulus kept", m, rv);
    endtask
    task automatic t_clear();
        wr(RAM_T, 2'h2, 64'hA5A5_5A5A_FFFF_0001);
        wr(RAM_A, 2'h0, 64'h1111_2222_3333_4444);
        run(ENTRY_CLEAR);
        wait_done(n);
        chk_vec("clear cmd length", 64'h40, n);
        rd(RAM_T, 2'h2, rv);
        chk_vec("t after clear", 64'h0, rv);
        rd(RAM_A, 2'h0, rv);
        chk_vec("a after clear", 64'h0, rv);
    endtask
    // Soft reset mid-subtract must abandon it and clear instead
    task automatic t_soft();
        wr(RAM_B, 2'h2, 64'h0F0F_0F0F_0F0F_0F0F);
        run(ENTRY_SUB);
        @(posedge clk);
        soft_reset <= 1'b1;
        @(posedge clk);
        soft_reset <= 1'b0;
        #1;
        chk_bit("busy after soft reset", 1'b1, busy);
        chk_bit("done after soft reset", 1'b0, done);
        wait_done(n);
        chk_vec("soft clear length", 64'h40, n);
        rd(RAM_B, 2'h2, rv);
        chk_vec("b after soft reset", 64'h0, rv);
    endtask

    // =============================================================
    // Closing report
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        t_reset();
        t_sub(64'h8000_0000_0000_1234, 64'h1234_5678_9ABC_DEF0, 64'hF123_4567_89AB_CDEF);
        t_sub(64'h1234_5678_9ABC_DEF0, 64'h8000_0000_0000_1234, 64'hF123_4567_89AB_CDEF);
        t_sub(64'h7777_0000_0000_0001, 64'h7777_0000_0000_0001, 64'hF123_4567_89AB_CDEF);
        t_refuse();
        t_r2(64'hC35A_0001_2345_6789);
        t_clear();
        t_soft();
        test_done();
    end
endmodule
`default_nettype wire
